// ### hw/prd_pkg.sv
// package: widths, carriers and reset values for the pad reset/direction block
package prd_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int N_CHAN   = 4;
  localparam int BOOT_W   = 4;
  localparam int EXT_IO_W = 16;
  localparam int GP_W     = 8;
  localparam int SCI_W    = 3;
  localparam int AUX_W    = 5;
  localparam int SAI_W    = 6;
  localparam int IN_W     = 15;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SCI_CLOCK_BIT = 0;  // then receive 1, transmit 2
  localparam int AUX_CLOCK_BIT = 0;  // controls 3:1, transmit 4

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tx_frame_clock;
    logic tx_bit_clock;
    logic rx1_frame_clock;
    logic rx1_bit_clock;
    logic rx0_frame_clock;
    logic rx0_bit_clock;
  } prd_sai_clk_t;

  typedef struct packed {
    logic [AUX_W-1:0]    aux;
    logic [SCI_W-1:0]    sci;
    logic [GP_W-1:0]     gp;
    logic [EXT_IO_W-1:0] ext;
  } prd_io_t;

  typedef struct packed {
    logic sci_as_gpio;
    logic aux_as_gpio;
    logic osc_out_off;
    logic sync_master;
    logic tx_master;
    logic rx1_master;
    logic rx0_master;
  } prd_cfg_t;

  typedef struct packed {
    logic por;
    logic bod33;
    logic bod18;
  } prd_supply_t;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam prd_cfg_t         CFG_RESET    = '0;
  localparam prd_io_t          IO_DIR_RESET = '0;
  localparam prd_io_t          IO_OUT_RESET = '0;
  localparam logic [BOOT_W-1:0] BOOT_RESET  = 4'h0;

endpackage : prd_pkg

// ### hw/prd_pad_sync.sv
// module: two-flop input synchroniser with registered drive and enable per pin
module prd_pad_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] pin_i,
  input  wire logic [W-1:0] drv_val,
  input  wire logic [W-1:0] drv_en,
  output logic      [W-1:0] pin_o,
  output logic      [W-1:0] pin_oe,
  output logic      [W-1:0] core_in
);

  logic [W-1:0] meta_q;

  // ----------------------------------------------------------------
  // input synchroniser, first stage read only by second
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q  <= '0;
      core_in <= '0;
    end else begin
      meta_q  <= pin_i;
      core_in <= meta_q;
    end
  end

  // registered drive; pads come up undriven
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_o  <= '0;
      pin_oe <= '0;
    end else begin
      pin_o  <= drv_val;
      pin_oe <= drv_en;
    end
  end

endmodule : prd_pad_sync

// ### hw/prd_pad_ctrl.sv
// module: pad reset state, direction and alternate function control
//
// Function
// RQ1: reset forces master clock, data out, low-side low
// RQ2: audio clocks driven as master, received as slave
// RQ3: audio clock pins are inputs out of reset
// RQ4: high-side outputs idle per strap during reset
// RQ5: strap high means high-side active low
// RQ6: sync master drives pin, slave listens
// RQ7: sync pin undriven while in reset
// RQ8: reset pin low initialises all logic; boot_mode, test_hw_reset and reset_out_n are not cleared by it
// RQ9: boot select captured on reset rising edge
// RQ10: boot value held from reset release
// RQ11: reset asserts internals, oscillator runs, pll off
// RQ12: reset out low on por or brownouts
// RQ13: test reset asserted together with system reset; test_hw_reset follows test_logic_reset_n alone, not system_reset_n
// RQ14: oscillator copy out, firmware may disable it
// RQ15: all general-purpose pins reset to inputs
// RQ16: serial comm pins reset input, gpio capable
// RQ17: aux audio pins reset input, gpio capable
// RQ18: test mode exposes brownouts, pll lock
// RQ19: test mode input held low normally
// RQ20: slave crystal fed from master oscillator
// RQ21: per-port role bit resets slave, steers enables
module prd_pad_ctrl
  import prd_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic               system_reset_n,
  input  wire logic               test_logic_reset_n,
  input  wire logic               test_mode,
  input  wire logic               test_pll_sel,
  input  wire logic               pll_lock,
  input  wire logic               pll_request,
  input  wire prd_supply_t        supply,
  input  wire logic [BOOT_W-1:0]  boot_select_inputs,
  input  wire logic               topology_polarity_strap,
  input  wire logic               crystal_in,
  output logic                    buffered_osc_out,
  output logic                    core_reset,
  output logic                    test_hw_reset,
  output logic                    pll_enable,
  output logic                    osc_run,
  output logic                    reset_out_n,
  output logic [BOOT_W-1:0]       boot_mode,
  output logic                    boot_valid,
  input  wire logic               cfg_we,
  input  wire prd_cfg_t           cfg_wdata,
  output prd_cfg_t                cfg_rdata,
  input  wire logic               io_dir_we,
  input  wire prd_io_t            io_dir_wdata,
  input  wire logic               io_out_we,
  input  wire prd_io_t            io_out_wdata,
  output prd_io_t                 io_in,
  input  wire prd_io_t            io_pin_i,
  output prd_io_t                 io_pin_o,
  output prd_io_t                 io_pin_oe,
  input  wire logic [SCI_W-1:0]   sci_fn_o,
  input  wire logic [SCI_W-1:0]   sci_fn_oe,
  input  wire logic [AUX_W-1:0]   aux_fn_o,
  input  wire logic [AUX_W-1:0]   aux_fn_oe,
  input  wire prd_sai_clk_t       sai_clk_core_o,
  output prd_sai_clk_t            sai_clk_core_in,
  input  wire prd_sai_clk_t       sai_clk_i,
  output prd_sai_clk_t            sai_clk_o,
  output prd_sai_clk_t            sai_clk_oe,
  input  wire logic               sync_core_o,
  output logic                    sync_core_in,
  input  wire logic               modulator_sync_i,
  output logic                    modulator_sync_o,
  output logic                    modulator_sync_oe,
  input  wire logic               rx0_serial_in,
  input  wire logic               rx1_serial_in,
  output logic [1:0]              rx_serial_core,
  input  wire logic               mclk_core,
  output logic                    mclk_out,
  input  wire logic               tx_data_core,
  output logic                    tx_serial_out,
  input  wire logic [N_CHAN-1:0]  high_side_core,
  input  wire logic [N_CHAN-1:0]  low_side_core,
  output logic [N_CHAN-1:0]       high_side_drive_out,
  output logic [N_CHAN-1:0]       low_side_drive_out
);

  // ----------------------------------------------------------------
  // synchronised pin inputs
  // ----------------------------------------------------------------
  logic [IN_W-1:0]  in_raw;
  logic [IN_W-1:0]  in_s;
  logic             nres_s, test_logic_reset_n_s, test_s, psel_s, lock_s, strap_s;
  prd_supply_t      sup_s;
  logic [BOOT_W-1:0] bms_s;
  logic             in_reset, rise, nres_d_q;
  prd_cfg_t         cfg_q;
  prd_io_t          dir_q, out_q, io_val_d, io_en_d;
  prd_sai_clk_t     sai_val_d, sai_en_d;

  assign in_raw = {system_reset_n, test_logic_reset_n, test_mode, test_pll_sel, pll_lock,
                   supply, boot_select_inputs, topology_polarity_strap,
                   rx1_serial_in, rx0_serial_in};
  assign {nres_s, test_logic_reset_n_s, test_s, psel_s, lock_s, sup_s, bms_s, strap_s,
          rx_serial_core} = in_s;

  prd_pad_sync #(.W(IN_W)) u_in_sync (
    .clk     (clk),
    .srst    (srst),
    .pin_i   (in_raw),
    .drv_val ('0),
    .drv_en  ('0),
    .pin_o   (),
    .pin_oe  (),
    .core_in (in_s)
  );

  // system reset held while pin low or local reset active
  assign in_reset = srst | ~nres_s; // RQ8
  assign rise     = nres_s & ~nres_d_q;

  // ----------------------------------------------------------------
  // reset fan-out and boot capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      nres_d_q      <= 1'b0;
      core_reset    <= 1'b1;
      test_hw_reset <= 1'b1;
      pll_enable    <= 1'b0;
      reset_out_n   <= 1'b0;
    end else begin
      nres_d_q      <= nres_s;
      core_reset    <= ~nres_s; // RQ11
      test_hw_reset <= ~test_logic_reset_n_s; // RQ13
      pll_enable    <= nres_s & pll_request; // RQ11
      reset_out_n   <= ~(sup_s.por | sup_s.bod33 | sup_s.bod18); // RQ12
    end
  end

  // oscillator keeps running in every state
  assign osc_run = 1'b1; // RQ11

  always_ff @(posedge clk) begin
    if (srst) begin
      boot_mode  <= BOOT_RESET;
      boot_valid <= 1'b0;
    end else if (rise) begin
      boot_mode  <= bms_s; // RQ9
      boot_valid <= 1'b1; // RQ10
    end else if (!nres_s) begin
      boot_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // firmware configuration, cleared by system reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (in_reset) begin
      cfg_q <= CFG_RESET; // RQ21
    end else if (cfg_we) begin
      cfg_q <= cfg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (in_reset) begin
      dir_q <= IO_DIR_RESET; // RQ15
    end else if (io_dir_we) begin
      dir_q <= io_dir_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (in_reset) begin
      out_q <= IO_OUT_RESET;
    end else if (io_out_we) begin
      out_q <= io_out_wdata;
    end
  end

  assign cfg_rdata = cfg_q;

  // oscillator copy gated by firmware; clock path, not registered
  assign buffered_osc_out = crystal_in & ~cfg_q.osc_out_off; // RQ14

  // ----------------------------------------------------------------
  // output-only pins: reset levels and polarity
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (in_reset) begin
      mclk_out            <= 1'b0; // RQ1
      tx_serial_out       <= 1'b0; // RQ1
      low_side_drive_out  <= '0; // RQ1
      high_side_drive_out <= {N_CHAN{strap_s}}; // RQ4
    end else begin
      mclk_out            <= mclk_core;
      tx_serial_out       <= tx_data_core;
      low_side_drive_out  <= low_side_core;
      high_side_drive_out <= high_side_core ^ {N_CHAN{strap_s}}; // RQ5
    end
  end

  // ----------------------------------------------------------------
  // audio clock pads: role picks direction, test mode overrides
  // ----------------------------------------------------------------
  always_comb begin
    sai_val_d                 = sai_clk_core_o;
    sai_en_d.rx0_bit_clock    = cfg_q.rx0_master & ~in_reset; // RQ2 RQ3
    sai_en_d.rx0_frame_clock  = cfg_q.rx0_master & ~in_reset;
    sai_en_d.rx1_bit_clock    = cfg_q.rx1_master & ~in_reset;
    sai_en_d.rx1_frame_clock  = cfg_q.rx1_master & ~in_reset;
    sai_en_d.tx_bit_clock     = cfg_q.tx_master & ~in_reset;
    sai_en_d.tx_frame_clock   = cfg_q.tx_master & ~in_reset;
    if (test_s) begin
      sai_val_d.tx_bit_clock   = sup_s.bod33; // RQ18
      sai_val_d.tx_frame_clock = psel_s ? lock_s : sup_s.bod18;
      sai_en_d.tx_bit_clock    = 1'b1;
      sai_en_d.tx_frame_clock  = 1'b1;
    end
  end

  prd_pad_sync #(.W(SAI_W)) u_sai_pads (
    .clk     (clk),
    .srst    (srst),
    .pin_i   (sai_clk_i),
    .drv_val (sai_val_d),
    .drv_en  (sai_en_d),
    .pin_o   (sai_clk_o),
    .pin_oe  (sai_clk_oe),
    .core_in (sai_clk_core_in)
  );

  // sync pin floats in reset, driven only by the master
  prd_pad_sync #(.W(1)) u_sync_pad (
    .clk     (clk),
    .srst    (srst),
    .pin_i   (modulator_sync_i),
    .drv_val (sync_core_o),
    .drv_en  (cfg_q.sync_master & ~in_reset), // RQ6 RQ7
    .pin_o   (modulator_sync_o),
    .pin_oe  (modulator_sync_oe),
    .core_in (sync_core_in)
  );

  // ----------------------------------------------------------------
  // general-purpose and alternate-function pads
  // ----------------------------------------------------------------
  always_comb begin
    io_val_d     = out_q;
    io_en_d      = dir_q;
    if (!cfg_q.sci_as_gpio) begin
      io_val_d.sci = sci_fn_o; // RQ16
      io_en_d.sci  = sci_fn_oe;
    end
    if (!cfg_q.aux_as_gpio) begin
      io_val_d.aux = aux_fn_o; // RQ17
      io_en_d.aux  = aux_fn_oe;
    end
    if (in_reset) begin
      io_en_d = '0; // RQ15 RQ16 RQ17
    end
  end

  prd_pad_sync #(.W($bits(prd_io_t))) u_io_pads (
    .clk     (clk),
    .srst    (srst),
    .pin_i   (io_pin_i),
    .drv_val (io_val_d),
    .drv_en  (io_en_d),
    .pin_o   (io_pin_o),
    .pin_oe  (io_pin_oe),
    .core_in (io_in)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_reset_low_outs: assert property (@(posedge clk) in_reset |=> // RQ1
    (mclk_out == 1'b0) && (tx_serial_out == 1'b0) && (low_side_drive_out == '0))
    else $error("low outputs not low in reset");
  a_clock_role_dir: assert property (@(posedge clk) disable iff (srst) // RQ2
    (!in_reset && !test_s) |=> (sai_clk_oe.rx0_bit_clock == $past(cfg_q.rx0_master))
      && (sai_clk_oe.tx_frame_clock == $past(cfg_q.tx_master)))
    else $error("audio clock direction wrong");
  a_clock_reset_in: assert property (@(posedge clk) // RQ3
    (in_reset && !test_s) |=> (sai_clk_oe == '0))
    else $error("audio clock driven in reset");
  a_high_idle_strap: assert property (@(posedge clk) disable iff (srst) in_reset |=> // RQ4
    high_side_drive_out == {N_CHAN{$past(strap_s)}})
    else $error("high side not idle in reset");
  a_high_polarity: assert property (@(posedge clk) !in_reset |=> // RQ5
    high_side_drive_out == ($past(high_side_core) ^ {N_CHAN{$past(strap_s)}}))
    else $error("high side polarity wrong");
  a_sync_master_dir: assert property (@(posedge clk) disable iff (srst) // RQ6
    !in_reset |=> modulator_sync_oe == $past(cfg_q.sync_master))
    else $error("sync pin direction wrong");
  a_sync_float: assert property (@(posedge clk) in_reset |=> !modulator_sync_oe) // RQ7
    else $error("sync pin driven in reset");
  a_cfg_cleared: assert property (@(posedge clk) in_reset |=> cfg_q == CFG_RESET) // RQ8
    else $error("config not cleared in reset");
  a_boot_capture: assert property (@(posedge clk) disable iff (srst) // RQ9
    rise |=> (boot_mode == $past(bms_s)) && boot_valid)
    else $error("boot mode not captured");
  a_boot_hold: assert property (@(posedge clk) disable iff (srst) // RQ10
    !rise |=> $stable(boot_mode))
    else $error("boot mode changed after capture");
  a_pll_off_reset: assert property (@(posedge clk) disable iff (srst) // RQ11
    !nres_s |=> core_reset && !pll_enable)
    else $error("pll on or core out of reset");
  a_reset_out: assert property (@(posedge clk) disable iff (srst) // RQ12
    (sup_s.por || sup_s.bod33 || sup_s.bod18) |=> !reset_out_n)
    else $error("reset out not asserted");
  a_osc_gate: assert property (@(posedge clk) // RQ14
    cfg_q.osc_out_off |-> !buffered_osc_out)
    else $error("oscillator copy not disabled");
  a_io_inputs: assert property (@(posedge clk) in_reset |=> io_pin_oe == '0) // RQ15
    else $error("general pins driven in reset");
  a_test_expose: assert property (@(posedge clk) disable iff (srst) // RQ18
    test_s |=> sai_clk_oe.tx_bit_clock && (sai_clk_o.tx_bit_clock == $past(sup_s.bod33)))
    else $error("brownout not exposed in test");

endmodule : prd_pad_ctrl

// ### tb/prd_far_side.sv
// far side model: converters, neighbour controller and external gpio sources on the pads
module prd_far_side
  import prd_pkg::*;
(
  input  wire prd_sai_clk_t sai_clk_o,
  input  wire prd_sai_clk_t sai_clk_oe,
  input  wire prd_sai_clk_t far_sai,
  output prd_sai_clk_t      sai_clk_i,
  input  wire logic         modulator_sync_o,
  input  wire logic         modulator_sync_oe,
  input  wire logic         far_sync,
  output logic              modulator_sync_i,
  input  wire prd_io_t      io_pin_o,
  input  wire prd_io_t      io_pin_oe,
  input  wire prd_io_t      far_io,
  output prd_io_t           io_pin_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------
  // audio clocks come from the converter side unless the device drives
  assign sai_clk_i = prd_sai_clk_t'((sai_clk_o & sai_clk_oe) | (far_sai & ~sai_clk_oe));
  // sync line: the neighbour master drives it while the device listens
  assign modulator_sync_i = modulator_sync_oe ? modulator_sync_o : far_sync;
  // general-purpose lines: external sources drive any pin the device releases
  assign io_pin_i = prd_io_t'((io_pin_o & io_pin_oe) | (far_io & ~io_pin_oe));
endmodule : prd_far_side

// ### tb/tb_prd_pad_ctrl.sv
// bench: reset state, direction and alternate function checks for the pad block
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("BAD at %0t: got %0h expected %0h", $time, got, exp); \
  end \
end

module tb_prd_pad_ctrl
  import prd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              clk, srst, system_reset_n, test_logic_reset_n, test_mode, test_pll_sel;
  logic              pll_lock, pll_request, topology_polarity_strap, crystal_in, cfg_we;
  logic              io_dir_we, io_out_we, sync_core_o, mclk_core, tx_data_core, far_sync;
  logic              rx0_serial_in, rx1_serial_in, buffered_osc_out, core_reset, osc_run;
  logic              test_hw_reset, pll_enable, reset_out_n, boot_valid, sync_core_in;
  logic              modulator_sync_i, modulator_sync_o, modulator_sync_oe;
  logic              mclk_out, tx_serial_out;
  logic [1:0]        rx_serial_core;
  logic [BOOT_W-1:0] boot_select_inputs, boot_mode;
  logic [SCI_W-1:0]  sci_fn_o, sci_fn_oe;
  logic [AUX_W-1:0]  aux_fn_o, aux_fn_oe;
  logic [N_CHAN-1:0] high_side_core, low_side_core, high_side_drive_out, low_side_drive_out;
  prd_supply_t       supply;
  prd_cfg_t          cfg_wdata, cfg_rdata;
  prd_io_t           io_dir_wdata, io_out_wdata, io_in, io_pin_i, io_pin_o, io_pin_oe, far_io;
  prd_sai_clk_t      sai_clk_core_o, sai_clk_core_in, sai_clk_i, sai_clk_o, sai_clk_oe, far_sai;
  int                failures, tests_run;

  prd_pad_ctrl prd_pad_ctrl_inst (
    .clk, .srst, .system_reset_n, .test_logic_reset_n, .test_mode, .test_pll_sel, .pll_lock,
    .pll_request, .supply, .boot_select_inputs, .topology_polarity_strap, .crystal_in,
    .buffered_osc_out, .core_reset, .test_hw_reset, .pll_enable, .osc_run, .reset_out_n,
    .boot_mode, .boot_valid, .cfg_we, .cfg_wdata, .cfg_rdata, .io_dir_we, .io_dir_wdata,
    .io_out_we, .io_out_wdata, .io_in, .io_pin_i, .io_pin_o, .io_pin_oe, .sci_fn_o,
    .sci_fn_oe, .aux_fn_o, .aux_fn_oe, .sai_clk_core_o, .sai_clk_core_in, .sai_clk_i,
    .sai_clk_o, .sai_clk_oe, .sync_core_o, .sync_core_in, .modulator_sync_i,
    .modulator_sync_o, .modulator_sync_oe, .rx0_serial_in, .rx1_serial_in, .rx_serial_core,
    .mclk_core, .mclk_out, .tx_data_core, .tx_serial_out, .high_side_core, .low_side_core,
    .high_side_drive_out, .low_side_drive_out
  );

  prd_far_side prd_far_side_inst (
    .sai_clk_o, .sai_clk_oe, .far_sai, .sai_clk_i, .modulator_sync_o, .modulator_sync_oe,
    .far_sync, .modulator_sync_i, .io_pin_o, .io_pin_oe, .far_io, .io_pin_i
  );

  // ----------------------------------------------------------------
  // clock and helpers
  // ----------------------------------------------------------------
  // 20 MHz clock
  always #25 clk = ~clk;

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : cyc

  task wr_cfg(input prd_cfg_t v);
    cfg_wdata = v;
    cfg_we = 1'b1;
    cyc(1);
    cfg_we = 1'b0;
    cyc(3);
  endtask : wr_cfg

  task wr_io(input prd_io_t d, input prd_io_t o);
    io_dir_wdata = d;
    io_out_wdata = o;
    {io_dir_we, io_out_we} = 2'b11;
    cyc(1);
    {io_dir_we, io_out_we} = 2'b00;
    cyc(3);
  endtask : wr_io

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // pin reset held with busy core drive: pads must sit in their reset states
  task t_reset_state(input logic strap);
    topology_polarity_strap = strap;
    {mclk_core, tx_data_core, sync_core_o, pll_request} = 4'hF;
    {low_side_core, high_side_core, sci_fn_oe, aux_fn_oe} = '1;
    sai_clk_core_o = 6'h3F;
    system_reset_n = 1'b0;
    test_logic_reset_n = 1'b0;
    cyc(4);
    wr_cfg(7'h7F);
    `CHK({mclk_out, tx_serial_out, low_side_drive_out}, 6'h00)
    `CHK(high_side_drive_out, {N_CHAN{strap}})
    `CHK(sai_clk_oe, 6'h00)
    `CHK(modulator_sync_oe, 1'b0)
    `CHK(io_pin_oe, 32'h0000_0000)
    `CHK(cfg_rdata, CFG_RESET)
    `CHK({core_reset, pll_enable, osc_run, boot_valid}, 4'hA)
    `CHK(test_hw_reset, 1'b1)
  endtask : t_reset_state

  // release reset, boot value latched and then held against pin changes
  task t_boot(input logic [BOOT_W-1:0] v);
    boot_select_inputs = v;
    cyc(1);
    system_reset_n = 1'b1;
    test_logic_reset_n = 1'b1;
    cyc(5);
    `CHK(boot_mode, v)
    `CHK({boot_valid, core_reset, pll_enable}, 3'b101)
    `CHK(test_hw_reset, 1'b0)
    boot_select_inputs = ~v;
    cyc(4);
    `CHK(boot_mode, v)
  endtask : t_boot

  // high-side polarity follows the strap, pass-through after reset
  task t_polarity();
    high_side_core = 4'h5;
    low_side_core = 4'h3;
    {rx1_serial_in, rx0_serial_in} = 2'b10;
    topology_polarity_strap = 1'b0;
    cyc(4);
    `CHK(high_side_drive_out, 4'h5)
    `CHK(rx_serial_core, 2'b10)
    `CHK({mclk_out, tx_serial_out, low_side_drive_out}, 6'h33)
    topology_polarity_strap = 1'b1;
    cyc(4);
    `CHK(high_side_drive_out, 4'hA)
  endtask : t_polarity

  // each supply monitor alone pulls the reset output low
  task t_supply();
    for (int i = 0; i < 3; i++) begin
      supply = prd_supply_t'(3'h1 << i);
      cyc(4);
      `CHK(reset_out_n, 1'b0)
      supply = '0;
      cyc(4);
      `CHK(reset_out_n, 1'b1)
    end
  endtask : t_supply

  // one role bit at a time: its clock pair or the sync pin driven, the others received
  task t_roles();
    logic [5:0] m;
    far_sai = 6'h2A;
    far_sync = 1'b0;
    for (int i = 0; i < 4; i++) begin
      m = (i < 3) ? 6'h03 << (2 * i) : 6'h00;
      wr_cfg(7'h01 << i);
      cyc(3);
      `CHK(cfg_rdata, 7'h01 << i)
      `CHK(sai_clk_oe, m)
      `CHK(sai_clk_core_in, m | (6'h2A & ~m))
      `CHK({modulator_sync_oe, sync_core_in}, {2{i == 3}})
    end
  endtask : t_roles

  // hardware test mode shows monitors on the transmit clock pins
  task t_test();
    test_mode = 1'b1;
    supply = 3'b010;
    test_pll_sel = 1'b1;
    pll_lock = 1'b1;
    cyc(5);
    `CHK({sai_clk_oe.tx_bit_clock, sai_clk_oe.tx_frame_clock}, 2'b11)
    `CHK({sai_clk_o.tx_bit_clock, sai_clk_o.tx_frame_clock}, 2'b11)
    test_pll_sel = 1'b0;
    cyc(4);
    `CHK({sai_clk_o.tx_bit_clock, sai_clk_o.tx_frame_clock}, 2'b10)
    supply = 3'b001;
    cyc(4);
    `CHK({sai_clk_o.tx_bit_clock, sai_clk_o.tx_frame_clock}, 2'b01)
    test_mode = 1'b0;
    supply = '0;
    cyc(4);
  endtask : t_test

  // oscillator copy on by default, then switched off; crystal as a master's copy
  task t_osc();
    crystal_in = 1'b1;
    cyc(1);
    `CHK(buffered_osc_out, 1'b1)
    wr_cfg(7'h10);
    `CHK(buffered_osc_out, 1'b0)
  endtask : t_osc

  // function path versus gpio path, then all pins back to inputs
  task t_gpio();
    sci_fn_oe = 3'h5;
    aux_fn_oe = 5'h00;
    wr_cfg(7'h00);
    wr_io(32'hFFFF_FFFF, 32'h5AC3_E10F);
    cyc(1);
    `CHK(io_pin_oe, 32'h05FF_FFFF)
    `CHK(io_pin_o & 32'h00FF_FFFF, 32'h00C3_E10F)
    wr_cfg(7'h60);
    cyc(1);
    `CHK(io_pin_oe, 32'hFFFF_FFFF)
    `CHK(io_pin_o, 32'h5AC3_E10F)
    far_io = 32'h1234_5678;
    wr_io(32'h0, 32'h0);
    cyc(2);
    `CHK(io_in, 32'h1234_5678)
  endtask : t_gpio

  // ----------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task final_report();
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // cuts a hang short well past the expected run of under two hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    final_report();
  end

  // main sequence: reset, scenarios, mid-run reset, second boot
  initial begin
    clk = 1'b0;
    {test_mode, test_pll_sel, pll_lock, crystal_in, cfg_we, io_dir_we, io_out_we} = '0;
    {far_sync, rx0_serial_in, rx1_serial_in, sci_fn_o, aux_fn_o, supply} = '0;
    {cfg_wdata, io_dir_wdata, io_out_wdata, far_io, far_sai, boot_select_inputs} = '0;
    {mclk_core, tx_data_core, sync_core_o, pll_request, topology_polarity_strap} = '0;
    {high_side_core, low_side_core, sci_fn_oe, aux_fn_oe, sai_clk_core_o} = '0;
    srst = 1'b1;
    system_reset_n = 1'b0;
    test_logic_reset_n = 1'b0;
    cyc(12);
    srst = 1'b0;
    t_reset_state(1'b1);
    t_reset_state(1'b0);
    t_boot(4'hC);
    t_polarity();
    t_supply();
    t_roles();
    t_test();
    t_osc();
    t_gpio();
    t_reset_state(1'b1);
    t_boot(4'h7);
    final_report();
  end
endmodule : tb_prd_pad_ctrl
